// ==== hdl/smcu_pkg.sv ====
// Constants, addresses and types of the stepper motion command unit
package smcu_pkg;
  // Register spaces of the host access ports
  localparam logic [1:0]  SP_COIL      = 2'h0;
  localparam logic [1:0]  SP_DISC      = 2'h1;
  localparam logic [1:0]  SP_INREG     = 2'h2;
  localparam logic [1:0]  SP_HOLD      = 2'h3;
  // Bit objects
  localparam logic [15:0] CO_LAUNCH    = 16'h5100;
  localparam logic [15:0] CO_APPLY     = 16'h5101;
  localparam logic [15:0] CO_AHALT     = 16'h5102;
  localparam logic [15:0] CO_AREL      = 16'h5103;
  localparam logic [15:0] CO_RHALT     = 16'h5104;
  localparam logic [15:0] CO_RREL      = 16'h5105;
  localparam logic [15:0] CO_FRAMING   = 16'h8100;
  localparam logic [15:0] CO_REBOOT    = 16'h8101;
  // Status word and its bit views
  localparam logic [15:0] IR_STATUS    = 16'h5037;
  localparam logic [15:0] DI_BASE      = 16'h5037;
  localparam logic [15:0] DI_LAST      = 16'h503d;
  localparam logic [15:0] IR_POS_LO    = 16'h5040;
  localparam logic [15:0] IR_POS_HI    = 16'h5041;
  localparam int          ST_FREE      = 0;
  localparam int          ST_HOLD      = 1;
  localparam int          ST_ACCEL     = 2;
  localparam int          ST_DECEL     = 3;
  localparam int          ST_STEADY    = 4;
  localparam int          ST_BUSY_POS  = 5;
  localparam int          ST_BUSY_CONT = 6;
  // Word registers
  localparam logic [15:0] HR_UP_CUR    = 16'h0367;
  localparam logic [15:0] HR_DN_CUR    = 16'h0368;
  localparam logic [15:0] HR_CRUISE_CURRENT   = 16'h0369;
  localparam logic [15:0] HR_STILL_CUR = 16'h036a;
  localparam logic [15:0] HR_OPCODE    = 16'h0376;
  localparam logic [15:0] HR_SENSE     = 16'h0377;
  localparam logic [15:0] HR_RATE      = 16'h0378;
  localparam logic [15:0] HR_UP_RATE   = 16'h0379;
  localparam logic [15:0] HR_DN_RATE   = 16'h037a;
  localparam logic [15:0] HR_GOAL_LO   = 16'h037b;
  localparam logic [15:0] HR_GOAL_HI   = 16'h037c;
  localparam logic [15:0] HR_BAUD      = 16'h8100;
  localparam logic [15:0] HR_PARITY    = 16'h8102;
  localparam logic [15:0] HR_STATION   = 16'h8103;
  // Opcodes
  localparam logic [3:0]  OP_CONT      = 4'h0;
  localparam logic [3:0]  OP_REL       = 4'h1;
  localparam logic [3:0]  OP_ABS       = 4'h2;
  localparam logic [3:0]  OP_ABS_FIX   = 4'h3;
  localparam logic [3:0]  OP_ZERO      = 4'h4;
  localparam logic [3:0]  OP_LAST      = 4'ha;
  // Fixed framing of the virtual serial port
  localparam logic        VSP_BINARY   = 1'b0;
  localparam logic [15:0] VSP_STATION  = 16'h0001;
  localparam logic [31:0] VSP_BAUD     = 32'h0001c200;
  localparam logic [3:0]  VSP_DATA     = 4'h7;
  localparam logic [15:0] PAR_ODD      = 16'h0001;
  localparam logic [15:0] PAR_EVEN     = 16'h0002;
  localparam logic [1:0]  VSP_STOP     = 2'h1;
  // Differential line settings after reset
  localparam logic        LINE_BIN_RST = 1'b0;
  localparam logic [31:0] LINE_BAUD_RST = 32'h0001c200;
  localparam logic [15:0] LINE_STN_RST = 16'h0001;
  localparam logic [15:0] LINE_PAR_RST = 16'h0002;

  typedef enum logic [5:0] {
    S_FREE = 6'h01,
    S_HOLD = 6'h02,
    S_RUN  = 6'h04,
    S_SEEK = 6'h08,
    S_RHLT = 6'h10,
    S_RREL = 6'h20
  } smcu_state_t;
endpackage : smcu_pkg

// ==== hdl/smcu_motion_cmd.sv ====
// Motion command unit: opcode launch, stop arbitration, currents, register ports
//
// Function
// R1 - Opcode 0 runs continuously with stored rate, ramps and sense, no goal.
// R2 - Opcode 1 moves relative to present location by the step goal.
// R3 - Opcode 2 seeks absolute goal, sense from location; opcode 3 uses stored sense.
// R4 - Opcode 4 is an absolute seek to location zero.
// R5 - Opcode 5 seeks switch rising edge, checks level first, ramps down, stops.
// R6 - Opcode 6 seeks switch rising edge without level check, ramps down, stops.
// R7 - Opcodes 7 and 8 seek rising edge then hold at once; 7 checks level.
// R8 - Opcodes 9 and 10 seek falling edge then hold; 9 checks level.
// R9 - Host loads opcode and settings before launching; motion starts only on launch.
// R10 - Writing 1 to apply-currents always applies; writing 0 does nothing.
// R11 - Applying loads four stored current words as active winding currents.
// R12 - Writing 1 to ramped halt ramps down then holds; 0 ignored.
// R13 - Writing 1 to ramped release ramps down then frees windings; 0 ignored.
// R14 - Ramped stops preempt launched motion, equal priority, lose to abrupt stops.
// R15 - Writing 1 to abrupt halt stops at once and holds; 0 ignored.
// R16 - Writing 1 to abrupt release stops at once, windings off; 0 ignored.
// R17 - Abrupt stops beat launch and ramped stops, equal top priority.
// R18 - Virtual serial port framing is fixed: ASCII, station 1, 115200, 7E1.
// R19 - Both host ports reach every word register and bit object alike.
// R20 - Changed line settings act only after reboot by power or reboot object; here only the reboot object applies them, sys_rst restores the reset values.
// R21 - Host writes station, framing, baud and parity, then reboots.
// R22 - Setting launch object starts the motion the opcode selects.
// R23 - Status bits 5 and 6 flag positioning and continuous commands unusable.
// R24 - Highest priority request in a cycle wins; later equal request replaces.
`timescale 1ns/10ps
`default_nettype none
module smcu_motion_cmd
  import smcu_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        a_we,
  input  wire logic        a_re,
  input  wire logic [1:0]  a_space,
  input  wire logic [15:0] a_addr,
  input  wire logic [31:0] a_wdata,
  output logic      [31:0] a_rdata,
  output logic             a_rvalid,
  output logic             a_err,
  input  wire logic        b_we,
  input  wire logic        b_re,
  input  wire logic [1:0]  b_space,
  input  wire logic [15:0] b_addr,
  input  wire logic [31:0] b_wdata,
  output logic      [31:0] b_rdata,
  output logic             b_rvalid,
  output logic             b_err,
  input  wire logic        limit_switch_line,
  input  wire logic [31:0] drive_pos,
  input  wire logic        drive_done,
  input  wire logic        drive_accel,
  input  wire logic        drive_decel,
  input  wire logic        drive_steady,
  output logic             drive_start,
  output logic             drive_continuous,
  output logic             drive_dir,
  output logic      [31:0] drive_target,
  output logic      [15:0] drive_rate,
  output logic      [15:0] drive_speed_up_rate,
  output logic      [15:0] drive_slow_down_rate,
  output logic             drive_ramp_stop,
  output logic             drive_abrupt_stop,
  output logic             windings_on,
  output logic      [15:0] speed_up_current,
  output logic      [15:0] slow_down_current,
  output logic      [15:0] cruise_current,
  output logic      [15:0] standstill_current,
  output logic             line_binary,
  output logic      [31:0] line_baud,
  output logic      [15:0] line_parity,
  output logic      [15:0] line_station,
  output logic             reboot_pulse,
  output logic             vsp_binary,
  output logic      [31:0] vsp_baud,
  output logic      [15:0] vsp_station,
  output logic      [3:0]  vsp_data_bits,
  output logic      [15:0] vsp_parity,
  output logic      [1:0]  vsp_stop_bits
);

  smcu_state_t state;
  smcu_state_t next_state;
  logic        p_we [2];
  logic        p_re [2];
  logic [1:0]  p_sp [2];
  logic [15:0] p_ad [2];
  logic [31:0] p_wd [2];
  logic [15:0] hr_up_cur, hr_dn_cur, hr_cruise_current, hr_still_cur;
  logic [3:0]  opcode;
  logic        turn_sense;
  logic [15:0] goal_lo, goal_hi;
  logic        cfg_binary;
  logic [31:0] cfg_baud;
  logic [15:0] cfg_parity, cfg_station;
  logic        t_launch, t_apply, t_ahalt, t_arel, t_rhalt, t_rrel, t_reboot;
  logic        abrupt_req, ramped_req, launch_ok, moving;
  logic        busy_pos, busy_cont, seek_grp;
  logic        sw_prev, seek_first, seek_chk, seek_fall, seek_ramp, seek_hit;
  logic [6:0]  status;
  logic [32:0] plan, rd_a, rd_b;
  logic        next_start, next_ramp, next_abrupt;

  assign p_we[0] = a_we;
  assign p_we[1] = b_we;
  assign p_re[0] = a_re;
  assign p_re[1] = b_re;
  assign p_sp[0] = a_space;
  assign p_sp[1] = b_space;
  assign p_ad[0] = a_addr;
  assign p_ad[1] = b_addr;
  assign p_wd[0] = a_wdata;
  assign p_wd[1] = b_wdata;

  // A write of 1 to one bit object from either port
  function automatic logic coil_one(input logic [15:0] obj);
    coil_one = 1'b0;
    for (int p = 0; p < 2; p++) begin
      if (p_we[p] && p_sp[p] == SP_COIL && p_ad[p] == obj && p_wd[p][0]) begin
        coil_one = 1'b1;
      end
    end
  endfunction : coil_one

  function automatic logic wr_hit(input logic [1:0] sp, input logic [15:0] ad);
    if (sp == SP_COIL) begin
      wr_hit = (ad >= CO_LAUNCH && ad <= CO_RREL) || ad == CO_FRAMING || ad == CO_REBOOT;
    end else if (sp == SP_HOLD) begin
      wr_hit = (ad >= HR_UP_CUR && ad <= HR_STILL_CUR) || (ad >= HR_OPCODE
               && ad <= HR_GOAL_HI) || ad == HR_BAUD || ad == HR_PARITY || ad == HR_STATION;
    end else begin
      wr_hit = 1'b0;
    end
  endfunction : wr_hit

  // Read answer: hit flag above the data word
  function automatic logic [32:0] rd_word(input logic [1:0] sp, input logic [15:0] ad);
    rd_word = {1'b1, 32'h00000000};
    case (sp)
      SP_COIL: begin
        if (ad == CO_FRAMING) begin
          rd_word[0] = cfg_binary;
        end else if (!wr_hit(sp, ad)) begin
          rd_word[32] = 1'b0;
        end
      end
      SP_DISC: begin
        if (ad >= DI_BASE && ad <= DI_LAST) begin
          rd_word[0] = status[3'(ad - DI_BASE)];
        end else begin
          rd_word[32] = 1'b0;
        end
      end
      SP_INREG: begin
        case (ad)
          IR_STATUS: rd_word[6:0] = status;
          IR_POS_LO: rd_word[15:0] = drive_pos[15:0];
          IR_POS_HI: rd_word[15:0] = drive_pos[31:16];
          default:   rd_word[32] = 1'b0;
        endcase
      end
      default: begin
        case (ad)
          HR_UP_CUR:    rd_word[15:0] = hr_up_cur;
          HR_DN_CUR:    rd_word[15:0] = hr_dn_cur;
          HR_CRUISE_CURRENT:   rd_word[15:0] = hr_cruise_current;
          HR_STILL_CUR: rd_word[15:0] = hr_still_cur;
          HR_OPCODE:    rd_word[3:0] = opcode;
          HR_SENSE:     rd_word[0] = turn_sense;
          HR_RATE:      rd_word[15:0] = drive_rate;
          HR_UP_RATE:   rd_word[15:0] = drive_speed_up_rate;
          HR_DN_RATE:   rd_word[15:0] = drive_slow_down_rate;
          HR_GOAL_LO:   rd_word[15:0] = goal_lo;
          HR_GOAL_HI:   rd_word[15:0] = goal_hi;
          HR_BAUD:      rd_word[31:0] = cfg_baud;
          HR_PARITY:    rd_word[15:0] = cfg_parity;
          HR_STATION:   rd_word[15:0] = cfg_station;
          default:      rd_word[32] = 1'b0;
        endcase
      end
    endcase
  endfunction : rd_word

  // Direction above target for the positioning opcodes
  function automatic logic [32:0] plan_move(input logic [3:0] op, input logic [31:0] goal);
    case (op)
      OP_REL:     plan_move = {turn_sense, turn_sense ? drive_pos + goal : drive_pos - goal}; // R2
      OP_ABS:     plan_move = {$signed(goal) >= $signed(drive_pos), goal}; // R3
      OP_ABS_FIX: plan_move = {turn_sense, goal}; // R3
      OP_ZERO:    plan_move = {$signed(drive_pos) <= 0, 32'h00000000}; // R4
      default:    plan_move = {turn_sense, goal}; // R1
    endcase
  endfunction : plan_move

  // The functions read module state, so they are called from a process
  always_comb begin
    t_launch = coil_one(CO_LAUNCH); // R22
    t_apply  = coil_one(CO_APPLY); // R10
    t_ahalt  = coil_one(CO_AHALT); // R15
    t_arel   = coil_one(CO_AREL); // R16
    t_rhalt  = coil_one(CO_RHALT); // R12
    t_rrel   = coil_one(CO_RREL); // R13
    t_reboot = coil_one(CO_REBOOT); // R20
    plan     = plan_move(opcode, {goal_hi, goal_lo});
    rd_a     = rd_word(a_space, a_addr);
    rd_b     = rd_word(b_space, b_addr);
  end
  assign abrupt_req = t_ahalt | t_arel;
  assign ramped_req = t_rhalt | t_rrel;
  assign moving     = state inside {S_RUN, S_SEEK, S_RHLT, S_RREL};
  assign busy_pos   = moving; // R23
  assign busy_cont  = state inside {S_RHLT, S_RREL}; // R23
  assign seek_grp   = opcode >= 4'h5 && opcode <= OP_LAST;
  assign launch_ok  = t_launch && opcode <= OP_LAST && ((opcode == OP_CONT || seek_grp)
                      ? !busy_cont : !busy_pos); // R9 R23
  assign status     = {busy_cont, busy_pos, drive_steady, drive_decel, drive_accel,
                       state == S_HOLD, state == S_FREE};
  assign seek_hit   = seek_fall ? ((sw_prev & ~limit_switch_line)
                      | (seek_first & seek_chk & ~limit_switch_line)) // R8
                      : ((~sw_prev & limit_switch_line)
                      | (seek_first & seek_chk & limit_switch_line)); // R5 R6 R7

  // Stop and launch arbitration
  always_comb begin
    next_state  = state;
    next_start  = 1'b0;
    next_ramp   = 1'b0;
    next_abrupt = 1'b0;
    if (abrupt_req) begin
      next_abrupt = 1'b1; // R17 R24
      next_state  = t_arel ? S_FREE : S_HOLD; // R15 R16
    end else if (ramped_req) begin
      if (moving) begin
        next_ramp  = 1'b1; // R14
        next_state = t_rrel ? S_RREL : S_RHLT; // R12 R13 R24
      end else begin
        next_state = t_rrel ? S_FREE : S_HOLD;
      end
    end else if (launch_ok) begin
      next_start = 1'b1; // R22
      if (seek_grp) begin
        next_state = S_SEEK;
      end else begin
        next_state = S_RUN; // R1
      end
    end else begin
      case (state)
        S_RUN: if (drive_done) next_state = S_HOLD;
        S_SEEK: begin
          if (seek_hit && seek_ramp) begin
            next_ramp  = 1'b1; // R5 R6
            next_state = S_RHLT;
          end else if (seek_hit) begin
            next_abrupt = 1'b1; // R7 R8
            next_state  = S_HOLD;
          end
        end
        S_RHLT: if (drive_done) next_state = S_HOLD; // R12
        S_RREL: if (drive_done) next_state = S_FREE; // R13
        S_FREE, S_HOLD: next_state = state;
        default: next_state = S_HOLD;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state             <= S_FREE;
      windings_on       <= 1'b0;
      drive_start       <= 1'b0;
      drive_ramp_stop   <= 1'b0;
      drive_abrupt_stop <= 1'b0;
      drive_continuous  <= 1'b0;
      drive_dir         <= 1'b0;
      drive_target      <= 32'h00000000;
    end else begin
      state             <= next_state;
      windings_on       <= next_state != S_FREE; // R13 R16
      drive_start       <= next_start;
      drive_ramp_stop   <= next_ramp;
      drive_abrupt_stop <= next_abrupt;
      if (next_start) begin
        drive_continuous <= opcode == OP_CONT || seek_grp; // R1
        drive_dir        <= plan[32];
        drive_target     <= plan[31:0];
      end
    end
  end

  // Switch seek bookkeeping
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sw_prev    <= 1'b0;
      seek_first <= 1'b0;
      seek_chk   <= 1'b0;
      seek_fall  <= 1'b0;
      seek_ramp  <= 1'b0;
    end else begin
      sw_prev    <= limit_switch_line;
      seek_first <= next_start && seek_grp;
      if (next_start && seek_grp) begin
        seek_chk  <= opcode[0]; // R5 R7 R8
        seek_fall <= opcode >= 4'h9; // R8
        seek_ramp <= opcode <= 4'h6; // R5 R6
      end
    end
  end

  // Word registers; port A wins a same-cycle write to one register
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      hr_up_cur <= 16'h0000;
      hr_dn_cur <= 16'h0000;
      hr_cruise_current <= 16'h0000;
      hr_still_cur <= 16'h0000;
      opcode <= OP_CONT;
      turn_sense <= 1'b0;
      drive_rate <= 16'h0000;
      drive_speed_up_rate <= 16'h0000;
      drive_slow_down_rate <= 16'h0000;
      goal_lo <= 16'h0000;
      goal_hi <= 16'h0000;
      cfg_binary <= LINE_BIN_RST;
      cfg_baud <= LINE_BAUD_RST;
      cfg_parity <= LINE_PAR_RST;
      cfg_station <= LINE_STN_RST;
    end else begin
      for (int p = 1; p >= 0; p--) begin
        if (p_we[p] && p_sp[p] == SP_COIL && p_ad[p] == CO_FRAMING) begin
          cfg_binary <= p_wd[p][0]; // R19
        end
        if (p_we[p] && p_sp[p] == SP_HOLD) begin
          case (p_ad[p]) // R19
            HR_UP_CUR:    hr_up_cur <= p_wd[p][15:0];
            HR_DN_CUR:    hr_dn_cur <= p_wd[p][15:0];
            HR_CRUISE_CURRENT:   hr_cruise_current <= p_wd[p][15:0];
            HR_STILL_CUR: hr_still_cur <= p_wd[p][15:0];
            HR_OPCODE:    opcode <= p_wd[p][3:0];
            HR_SENSE:     turn_sense <= p_wd[p][0];
            HR_RATE:      drive_rate <= p_wd[p][15:0];
            HR_UP_RATE:   drive_speed_up_rate <= p_wd[p][15:0];
            HR_DN_RATE:   drive_slow_down_rate <= p_wd[p][15:0];
            HR_GOAL_LO:   goal_lo <= p_wd[p][15:0];
            HR_GOAL_HI:   goal_hi <= p_wd[p][15:0];
            HR_BAUD:      cfg_baud <= p_wd[p];
            HR_PARITY:    cfg_parity <= p_wd[p][15:0];
            HR_STATION:   cfg_station <= p_wd[p][15:0];
            default:      cfg_station <= cfg_station;
          endcase
        end
      end
    end
  end

  // Active currents follow the stored words only on apply
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      speed_up_current   <= 16'h0000;
      slow_down_current  <= 16'h0000;
      cruise_current     <= 16'h0000;
      standstill_current <= 16'h0000;
    end else if (t_apply) begin
      speed_up_current   <= hr_up_cur; // R11
      slow_down_current  <= hr_dn_cur; // R11
      cruise_current     <= hr_cruise_current; // R11
      standstill_current <= hr_still_cur; // R11
    end
  end

  // Line settings in force change only at reboot
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      line_binary  <= LINE_BIN_RST;
      line_baud    <= LINE_BAUD_RST;
      line_parity  <= LINE_PAR_RST;
      line_station <= LINE_STN_RST;
      reboot_pulse <= 1'b0;
    end else begin
      reboot_pulse <= t_reboot;
      if (t_reboot) begin
        line_binary  <= cfg_binary; // R20
        line_baud    <= cfg_baud; // R20
        line_parity  <= cfg_parity; // R20
        line_station <= cfg_station; // R20
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      vsp_binary    <= 1'b0;
      vsp_baud      <= 32'h00000000;
      vsp_station   <= 16'h0000;
      vsp_data_bits <= 4'h0;
      vsp_parity    <= 16'h0000;
      vsp_stop_bits <= 2'h0;
    end else begin
      vsp_binary    <= VSP_BINARY; // R18
      vsp_baud      <= VSP_BAUD; // R18
      vsp_station   <= VSP_STATION; // R18
      vsp_data_bits <= VSP_DATA; // R18
      vsp_parity    <= PAR_EVEN; // R18
      vsp_stop_bits <= VSP_STOP; // R18
    end
  end

  // Read answers one cycle after the strobe; unmapped access flags an error
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      a_rdata  <= 32'h00000000;
      a_rvalid <= 1'b0;
      a_err    <= 1'b0;
      b_rdata  <= 32'h00000000;
      b_rvalid <= 1'b0;
      b_err    <= 1'b0;
    end else begin
      a_rvalid <= a_re;
      b_rvalid <= b_re; // R19
      a_rdata  <= a_re ? rd_a[31:0] : 32'h00000000;
      b_rdata  <= b_re ? rd_b[31:0] : 32'h00000000;
      a_err    <= (a_re && !rd_a[32]) || (a_we && !wr_hit(a_space, a_addr));
      b_err    <= (b_re && !rd_b[32]) || (b_we && !wr_hit(b_space, b_addr));
    end
  end

  AST_ABRUPT_TOP: assert property (@(posedge mclk) disable iff (sys_rst) // R17
    abrupt_req |=> drive_abrupt_stop && !drive_start && !drive_ramp_stop)
    else $error("abrupt stop did not win");
  AST_ABRUPT_FREE: assert property (@(posedge mclk) disable iff (sys_rst) // R16
    t_arel |=> !windings_on && state == S_FREE)
    else $error("abrupt release left windings on");
  AST_ABRUPT_HOLD: assert property (@(posedge mclk) disable iff (sys_rst) // R15
    t_ahalt && !t_arel |=> windings_on && state == S_HOLD)
    else $error("abrupt halt did not hold");
  AST_RAMP_OVER_LAUNCH: assert property (@(posedge mclk) disable iff (sys_rst) // R14
    ramped_req && !abrupt_req && moving |=> drive_ramp_stop && !drive_start)
    else $error("ramped stop lost to launch");
  AST_APPLY_CUR: assert property (@(posedge mclk) disable iff (sys_rst) // R11
    t_apply |=> speed_up_current == $past(hr_up_cur)
      && standstill_current == $past(hr_still_cur))
    else $error("currents not applied");
  AST_ZERO_TARGET: assert property (@(posedge mclk) disable iff (sys_rst) // R4
    launch_ok && !abrupt_req && !ramped_req && opcode == OP_ZERO
      |=> drive_start && drive_target == 32'h00000000 && !drive_continuous)
    else $error("zero return target wrong");
  AST_CONT_START: assert property (@(posedge mclk) disable iff (sys_rst) // R1
    launch_ok && !abrupt_req && !ramped_req && opcode == OP_CONT
      |=> drive_start && drive_continuous && state == S_RUN)
    else $error("continuous launch wrong");
  AST_LINE_STABLE: assert property (@(posedge mclk) disable iff (sys_rst) // R20
    !t_reboot |=> $stable(line_baud) && $stable(line_station) && !reboot_pulse)
    else $error("line settings changed without reboot");
  AST_SEEK_HOLD: assert property (@(posedge mclk) disable iff (sys_rst) // R7
    state == S_SEEK && seek_hit && !seek_ramp && !abrupt_req && !ramped_req && !launch_ok
      |=> state == S_HOLD && drive_abrupt_stop)
    else $error("seek edge did not hold");

endmodule : smcu_motion_cmd
`default_nettype wire

// ==== tb/smcu_host_model.sv ====
// Host master model on the differential-line register port
`timescale 1ns/10ps
`default_nettype none
module smcu_host_model (
  output var logic        we,
  output var logic [1:0]  space,
  output var logic [15:0] addr,
  output var logic [31:0] wdata,
  input  wire logic       mclk
);
  initial begin
    we = 1'b0;
    space = 2'h0;
    addr = 16'h0000;
    wdata = 32'h0;
  end

  // Writes settings or bit objects, also during motion; one write per call
  task automatic wr(input logic [1:0] s, input logic [15:0] a, input logic [31:0] d);
    @(negedge mclk);
    we <= 1'b1;
    space <= s;
    addr <= a;
    wdata <= d;
    @(negedge mclk);
    we <= 1'b0;
    wdata <= ~d;
  endtask : wr
endmodule : smcu_host_model
`default_nettype wire

// ==== tb/test_stepper_motion_command_unit.sv ====
// Self-checking bench of the motion command unit
`timescale 1ns/10ps
`default_nettype none
module test_stepper_motion_command_unit;
  import smcu_pkg::*;
  logic        mclk, sys_rst, a_we, a_re, b_we, limit_switch_line, drive_done;
  logic        a_err, drive_start, drive_continuous, drive_dir, drive_ramp_stop;
  logic        drive_abrupt_stop, windings_on, reboot_pulse;
  logic [1:0]  a_space, b_space;
  logic [15:0] a_addr, b_addr, speed_up_current, slow_down_current;
  logic [15:0] cruise_current, standstill_current;
  logic [31:0] a_wdata, b_wdata, drive_pos, a_rdata, drive_target, line_baud, vsp_baud;
  logic [3:0]  vsp_data_bits;
  logic [31:0] rd;
  int          error_cnt, n_checks;

  smcu_motion_cmd smcu_motion_cmd_i (.mclk, .sys_rst, .a_we, .a_re, .a_space, .a_addr,
    .a_wdata, .a_rdata, .a_rvalid(), .a_err, .b_we, .b_re(1'b0), .b_space, .b_addr,
    .b_wdata, .b_rdata(), .b_rvalid(), .b_err(), .limit_switch_line, .drive_pos,
    .drive_done, .drive_accel(1'b0), .drive_decel(1'b0), .drive_steady(1'b0),
    .drive_start, .drive_continuous, .drive_dir, .drive_target, .drive_rate(),
    .drive_speed_up_rate(), .drive_slow_down_rate(), .drive_ramp_stop,
    .drive_abrupt_stop, .windings_on, .speed_up_current, .slow_down_current,
    .cruise_current, .standstill_current, .line_binary(), .line_baud, .line_parity(),
    .line_station(), .reboot_pulse, .vsp_binary(), .vsp_baud, .vsp_station(),
    .vsp_data_bits, .vsp_parity(), .vsp_stop_bits());
  smcu_host_model smcu_host_model_i (.we(b_we), .space(b_space), .addr(b_addr),
    .wdata(b_wdata), .mclk);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wa(input logic [1:0] s, input logic [15:0] a, input logic [31:0] d);
    @(negedge mclk);
    a_we = 1'b1;
    a_space = s;
    a_addr = a;
    a_wdata = d;
    @(negedge mclk);
    a_we = 1'b0;
  endtask : wa

  task automatic ra(input logic [15:0] a);
    @(negedge mclk);
    a_re = 1'b1;
    a_space = SP_INREG;
    a_addr = a;
    @(negedge mclk);
    a_re = 1'b0;
    rd = a_rdata;
  endtask : ra

  task automatic print_verdict;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task automatic t_reset;
    @(negedge mclk);
    chk(windings_on, 0);
    chk(vsp_baud, 32'h1c200);
    chk(vsp_data_bits, 4'h7);
  endtask : t_reset

  task automatic t_apply;
    smcu_host_model_i.wr(SP_HOLD, HR_UP_CUR, 32'h5dc);
    smcu_host_model_i.wr(SP_HOLD, HR_DN_CUR, 32'h5dc);
    smcu_host_model_i.wr(SP_HOLD, HR_CRUISE_CURRENT, 32'h4b0);
    smcu_host_model_i.wr(SP_HOLD, HR_STILL_CUR, 32'h258);
    wa(SP_COIL, CO_APPLY, 32'h0);
    chk(cruise_current, 16'h0);
    wa(SP_COIL, CO_APPLY, 32'h1);
    chk({speed_up_current, slow_down_current}, 32'h05dc05dc);
    chk({cruise_current, standstill_current}, 32'h04b00258);
  endtask : t_apply

  task automatic t_launch;
    wa(SP_HOLD, HR_GOAL_LO, 32'h64);
    wa(SP_HOLD, HR_SENSE, 32'h1);
    wa(SP_HOLD, HR_OPCODE, 32'h2);
    chk(drive_start, 0);
    wa(SP_COIL, CO_LAUNCH, 32'h1);
    chk({drive_start, drive_continuous, drive_dir}, 3'b100);
    chk(drive_target, 32'h64);
    ra(IR_STATUS);
    chk(rd[5], 1);
  endtask : t_launch

  task automatic t_ramp;
    wa(SP_COIL, CO_RHALT, 32'h1);
    chk(drive_ramp_stop, 1);
    drive_done = 1'b1;
    @(negedge mclk);
    drive_done = 1'b0;
    ra(IR_STATUS);
    chk(rd[1:0], 2'b10);
  endtask : t_ramp

  task automatic t_prio;
    wa(SP_COIL, CO_LAUNCH, 32'h1);
    fork
      wa(SP_COIL, CO_AREL, 32'h1);
      smcu_host_model_i.wr(SP_COIL, CO_RHALT, 32'h1);
    join
    chk({drive_abrupt_stop, drive_ramp_stop, windings_on}, 3'b100);
    wa(SP_INREG, IR_STATUS, 32'h1);
    chk(a_err, 1);
  endtask : t_prio

  task automatic t_seek;
    limit_switch_line = 1'b1;
    wa(SP_HOLD, HR_OPCODE, 32'h7);
    wa(SP_COIL, CO_LAUNCH, 32'h1);
    chk(drive_continuous, 1);
    for (int i = 0; i < 4 && drive_abrupt_stop !== 1'b1; i++) @(negedge mclk);
    chk(drive_abrupt_stop, 1);
  endtask : t_seek

  task automatic t_modes;
    wa(SP_HOLD, HR_OPCODE, 32'h4);
    wa(SP_COIL, CO_LAUNCH, 32'h1);
    chk({drive_start, drive_continuous, drive_dir}, 3'b100);
    chk(drive_target, 32'h0);
    wa(SP_HOLD, HR_OPCODE, 32'h1);
    wa(SP_COIL, CO_LAUNCH, 32'h1);
    chk(drive_start, 0);
    wa(SP_COIL, CO_AHALT, 32'h1);
    chk({drive_abrupt_stop, windings_on}, 2'b11);
    wa(SP_COIL, CO_LAUNCH, 32'h1);
    chk({drive_start, drive_continuous, drive_dir}, 3'b101);
    chk(drive_target, 32'h12c);
    wa(SP_HOLD, HR_OPCODE, 32'h0);
    wa(SP_COIL, CO_LAUNCH, 32'h1);
    chk({drive_start, drive_continuous}, 2'b11);
  endtask : t_modes

  task automatic t_boot;
    smcu_host_model_i.wr(SP_HOLD, HR_BAUD, 32'h1f400);
    chk(line_baud, 32'h1c200);
    wa(SP_COIL, CO_REBOOT, 32'h1);
    chk(reboot_pulse, 1);
    chk(line_baud, 32'h1f400);
  endtask : t_boot

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    #20000;
    error_cnt++;
    print_verdict();
  end

  initial begin
    {sys_rst, a_we, a_re, limit_switch_line, drive_done} = 5'b10000;
    {a_space, a_addr, a_wdata} = '0;
    drive_pos = 32'hc8;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    t_reset();
    t_apply();
    t_launch();
    t_ramp();
    t_prio();
    t_seek();
    t_modes();
    t_boot();
    print_verdict();
  end
endmodule : test_stepper_motion_command_unit
`default_nettype wire
